// ### common/rcfe_pkg.sv
// constants, types and codes of the remote command front end
package rcfe_pkg;
	typedef logic [7:0] rcfe_byte_t;
	typedef logic [3:0] rcfe_nib_t;
	typedef logic [4:0] rcfe_paddr_t;

	// character codes
	localparam rcfe_byte_t CH_CR = 8'h0d;
	localparam rcfe_byte_t CH_LF = 8'h0a;
	localparam rcfe_byte_t CH_DOLLAR = 8'h24;
	localparam rcfe_byte_t CH_AT = 8'h40;
	localparam rcfe_byte_t CH_AMP = 8'h26;
	localparam rcfe_byte_t CH_BANG = 8'h21;
	localparam rcfe_byte_t CH_QMARK = 8'h3f;
	localparam rcfe_byte_t CH_TILDE = 8'h7e;
	localparam rcfe_byte_t CH_Q = 8'h51;
	localparam rcfe_byte_t CH_U = 8'h55;
	localparam rcfe_byte_t CH_ZERO = 8'h30;
	localparam rcfe_byte_t CH_NINE = 8'h39;

	// address limits and reset values
	localparam rcfe_nib_t BUS_ADDR_MIN = 4'h1;
	localparam rcfe_nib_t BUS_ADDR_MAX = 4'h9;
	localparam rcfe_nib_t GW_MASTER_ADDR = 4'h0;
	localparam rcfe_paddr_t PAR_ADDR_RESET = 5'd25;
	localparam rcfe_paddr_t PAR_ADDR_OFF = 5'd0;

	// protocol select digit fields
	localparam int QSEL_CRLF_BIT = 1;
	localparam int QSEL_EXT_BIT = 2;

	// status byte field positions
	localparam int SB_RQS_BIT = 6;
	localparam int SB_MAV_BIT = 4;
	localparam int SB_RDY_BIT = 1;

	// output buffer geometry
	localparam int OBUF_AW = 4;
	localparam int OBUF_DEPTH = 16;

	// status refresh period
	localparam int CLK_PERIOD_NS = 10;
	localparam int STATUS_PERIOD_NS = 1000000;
	localparam int STATUS_TICK_CYCLES = STATUS_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		PS_START = 4'b0001,
		PS_ADDR = 4'b0010,
		PS_BODY = 4'b0100,
		PS_SKIP = 4'b1000
	} rcfe_pstate_t;

	typedef enum logic [3:0] {
		OS_DATA = 4'b0001,
		OS_QMARK = 4'b0010,
		OS_CR = 4'b0100,
		OS_LF = 4'b1000
	} rcfe_ostate_t;
endpackage

// ### design/rcfe_top.sv
// remote command front end: prefix filter, settings, reply framing, parallel-bus buffer and status byte
`timescale 1ns/100ps
module rcfe_top #(
	parameter int STATUS_TICK = rcfe_pkg::STATUS_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	// serial port byte streams (uart on this clock)
	input wire logic ser_rx_valid_i,
	input wire rcfe_pkg::rcfe_byte_t ser_rx_data_i,
	output logic ser_tx_valid_o,
	output rcfe_pkg::rcfe_byte_t ser_tx_data_o,
	input wire logic ser_tx_ready_i,
	// parallel bus port (bus handshake logic on this clock)
	input wire logic par_ren_i,
	input wire logic par_talk_i,
	input wire logic par_listen_i,
	input wire logic par_rx_valid_i,
	input wire rcfe_pkg::rcfe_byte_t par_rx_data_i,
	input wire logic par_tx_read_i,
	input wire logic par_dev_clear_i,
	input wire logic par_poll_read_i,
	output rcfe_pkg::rcfe_byte_t par_tx_data_o,
	output logic par_tx_avail_o,
	output logic par_eoi_o,
	output logic par_srq_o,
	output rcfe_pkg::rcfe_byte_t status_byte_o,
	output logic par_active_o,
	// test mode and non-volatile storage
	input wire logic test_mode_i,
	input wire logic test_exit_i,
	input wire logic test_par_addr_we_i,
	input wire rcfe_pkg::rcfe_paddr_t test_par_addr_i,
	input wire rcfe_pkg::rcfe_nib_t nv_bus_addr_i,
	output logic nv_store_o,
	output rcfe_pkg::rcfe_nib_t nv_bus_addr_o,
	output rcfe_pkg::rcfe_nib_t bus_addr_o,
	// command handler side
	output logic cmd_valid_o,
	output rcfe_pkg::rcfe_byte_t cmd_data_o,
	output logic cmd_end_o,
	output logic cmd_reply_en_o,
	output logic ext_res_o,
	output logic crlf_o,
	input wire logic rsp_valid_i,
	input wire rcfe_pkg::rcfe_byte_t rsp_data_i,
	input wire logic rsp_last_i,
	input wire logic cmd_reject_i,
	output logic rsp_ready_o
);
	import rcfe_pkg::*;

	// ren pin synchroniser
	logic ren_meta;
	logic ren_sync;
	always_ff @(posedge clk_i) begin
		ren_meta <= par_ren_i;
		ren_sync <= ren_meta;
	end

	// settings and port state
	logic par_active;
	rcfe_paddr_t par_addr;
	rcfe_nib_t bus_addr;
	logic addr_loaded;
	logic unlocked;
	logic ext_res;
	logic crlf;

	// parallel port entry: only with a nonzero address, then sticky until restart
	wire par_enabled = (par_addr != PAR_ADDR_OFF);
	wire par_enter = par_enabled & ren_sync & (par_talk_i | par_listen_i);
	always_ff @(posedge clk_i) begin
		if (!rstn_i || test_exit_i) begin
			par_active <= 1'b0;
		end else if (par_enter) begin
			par_active <= 1'b1;
		end
	end

	// parallel address lives in test-mode settings, no remote path writes it
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			par_addr <= PAR_ADDR_RESET;
		end else if (test_mode_i && test_par_addr_we_i) begin
			par_addr <= test_par_addr_i;
		end
	end

	// input selection: exactly one port feeds the parser
	wire in_valid = par_active ? par_rx_valid_i : ser_rx_valid_i;
	wire rcfe_byte_t in_data = par_active ? par_rx_data_i : ser_rx_data_i;

	// character classes
	wire is_cr = (in_data == CH_CR);
	wire is_lf = (in_data == CH_LF);
	wire is_digit = (in_data >= CH_ZERO) && (in_data <= CH_NINE);
	wire rcfe_nib_t digit_val = in_data[3:0];

	// parser state and prefix flags
	rcfe_pstate_t pst;
	logic suppress;
	logic literal;
	rcfe_byte_t letter;
	rcfe_nib_t last_digit;
	logic any_nonzero;
	logic reply_ok;

	// the gateway master answers to address zero while the parallel port rules
	wire rcfe_nib_t own_addr = par_active ? GW_MASTER_ADDR : bus_addr;
	wire pfx_dollar = ~literal & (in_data == CH_DOLLAR);
	wire pfx_at = ~literal & (in_data == CH_AT);
	wire pfx_amp = ~literal & (in_data == CH_AMP);
	wire at_start = in_valid & (pst == PS_START);
	wire start_body = at_start & ~is_cr & ~is_lf & ~pfx_dollar & ~pfx_at & ~pfx_amp;
	wire body_byte = in_valid & (pst == PS_BODY) & ~is_cr;
	wire body_end = in_valid & (pst == PS_BODY) & is_cr;
	wire addr_hit = is_digit & (digit_val == own_addr);
	wire cmd_is_q = (letter == CH_Q);
	wire cmd_is_u = (letter == CH_U);
	wire cmd_is_bang = (letter == CH_BANG);
	wire cmd_is_store = (letter == CH_TILDE);
	wire digit_in_range = (last_digit >= BUS_ADDR_MIN) && (last_digit <= BUS_ADDR_MAX);

	// parser sequencing; a bare LF between commands is dropped at start
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pst <= PS_START;
		end else if (in_valid) begin
			case (pst)
				PS_START: begin
					if (pfx_at) begin
						pst <= PS_ADDR;
					end else if (start_body) begin
						pst <= PS_BODY;
					end
				end
				PS_ADDR: begin
					if (is_cr) begin
						pst <= PS_START;
					end else if (addr_hit) begin
						pst <= PS_START;
					end else begin
						pst <= PS_SKIP;
					end
				end
				PS_BODY: begin
					if (is_cr) begin
						pst <= PS_START;
					end
				end
				PS_SKIP: begin
					if (is_cr) begin
						pst <= PS_START;
					end
				end
				default: begin
					pst <= PS_START;
				end
			endcase
		end
	end

	// prefix flags last for one command and are wiped at its CR
	always_ff @(posedge clk_i) begin
		if (!rstn_i || (in_valid && is_cr)) begin
			suppress <= 1'b0;
			literal <= 1'b0;
		end else if (at_start && pfx_dollar) begin
			suppress <= 1'b1;
		end else if (at_start && pfx_amp) begin
			literal <= 1'b1;
		end
	end

	// command letter and parameter digits
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			letter <= 8'h00;
			last_digit <= 4'h0;
			any_nonzero <= 1'b0;
		end else if (start_body) begin
			letter <= in_data;
			last_digit <= 4'h0;
			any_nonzero <= 1'b0;
		end else if (body_byte && is_digit) begin
			last_digit <= digit_val;
			any_nonzero <= any_nonzero | (digit_val != 4'h0);
		end
	end

	// forward command text to the handlers, one byte per cycle
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cmd_valid_o <= 1'b0;
			cmd_data_o <= 8'h00;
			cmd_end_o <= 1'b0;
		end else begin
			cmd_valid_o <= start_body | body_byte;
			cmd_data_o <= in_data;
			cmd_end_o <= body_end;
		end
	end

	// reply permission: none under dollar, none for protocol select
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			reply_ok <= 1'b0;
			cmd_reply_en_o <= 1'b0;
		end else if (body_end) begin
			reply_ok <= ~suppress & ~cmd_is_q;
			cmd_reply_en_o <= ~suppress & ~cmd_is_q;
		end
	end

	// protocol select and unlock take effect at the command's CR
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ext_res <= 1'b0;
			crlf <= 1'b0;
			unlocked <= 1'b0;
		end else if (body_end && cmd_is_q) begin
			ext_res <= last_digit[QSEL_EXT_BIT];
			crlf <= last_digit[QSEL_CRLF_BIT];
		end else if (body_end && cmd_is_u) begin
			unlocked <= any_nonzero;
		end
	end

	// bus address: loaded from storage once after reset release, never as a reset value
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			addr_loaded <= 1'b0;
			bus_addr <= BUS_ADDR_MIN;
		end else if (!addr_loaded) begin
			addr_loaded <= 1'b1;
			bus_addr <= nv_bus_addr_i;
		end else if (body_end && cmd_is_bang && unlocked && digit_in_range) begin
			bus_addr <= last_digit;
		end
	end

	// storage write only on store command or test exit
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			nv_store_o <= 1'b0;
			nv_bus_addr_o <= BUS_ADDR_MIN;
		end else begin
			nv_store_o <= (body_end & cmd_is_store) | test_exit_i;
			nv_bus_addr_o <= bus_addr;
		end
	end

	// reply framing: handler text, optional '?', then CR and maybe LF
	rcfe_ostate_t ost;
	logic out_valid;
	rcfe_byte_t out_data;
	logic out_ready;
	logic out_term;
	always_comb begin
		out_valid = 1'b0;
		out_data = rsp_data_i;
		out_term = 1'b0;
		rsp_ready_o = 1'b0;
		case (ost)
			OS_DATA: begin
				out_valid = rsp_valid_i & reply_ok;
				rsp_ready_o = reply_ok ? out_ready : 1'b1;
			end
			OS_QMARK: begin
				out_valid = 1'b1;
				out_data = CH_QMARK;
			end
			OS_CR: begin
				out_valid = 1'b1;
				out_data = CH_CR;
				out_term = ~crlf;
			end
			OS_LF: begin
				out_valid = 1'b1;
				out_data = CH_LF;
				out_term = 1'b1;
			end
			default: begin
				out_valid = 1'b0;
			end
		endcase
	end

	wire out_fire = out_valid & out_ready;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ost <= OS_DATA;
		end else begin
			case (ost)
				OS_DATA: begin
					if (cmd_reject_i && reply_ok) begin
						ost <= OS_QMARK;
					end else if (out_fire && rsp_last_i) begin
						ost <= OS_CR;
					end
				end
				OS_QMARK: begin
					if (out_fire) begin
						ost <= OS_CR;
					end
				end
				OS_CR: begin
					if (out_fire) begin
						ost <= crlf ? OS_LF : OS_DATA;
					end
				end
				OS_LF: begin
					if (out_fire) begin
						ost <= OS_DATA;
					end
				end
				default: begin
					ost <= OS_DATA;
				end
			endcase
		end
	end

	// serial output stage, a single holding register keeps data on flops
	wire ser_take = ~ser_tx_valid_o | ser_tx_ready_i;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ser_tx_valid_o <= 1'b0;
			ser_tx_data_o <= 8'h00;
		end else if (ser_take) begin
			ser_tx_valid_o <= out_valid & ~par_active;
			ser_tx_data_o <= out_data;
		end
	end

	// parallel output buffer; bit 8 marks the byte that closes a message
	logic [8:0] obuf [0:OBUF_DEPTH-1];
	logic [OBUF_AW-1:0] wr_ptr;
	logic [OBUF_AW-1:0] rd_ptr;
	logic [OBUF_AW:0] count;
	logic [OBUF_AW:0] msg_count;
	wire buf_full = (count == OBUF_DEPTH[OBUF_AW:0]);
	wire buf_avail = (count != '0);
	wire msg_avail = (msg_count != '0);
	assign out_ready = par_active ? ~buf_full : ser_take;
	wire push = out_fire & par_active;
	wire pop = par_tx_read_i & buf_avail;
	wire pop_term = pop & obuf[rd_ptr][8];
	wire push_term = push & out_term;
	wire buf_clear = par_dev_clear_i | (body_end & cmd_is_q);

	// buffer write side, no reset needed on the storage itself
	always_ff @(posedge clk_i) begin
		if (push) begin
			obuf[wr_ptr] <= {out_term, out_data};
		end
	end

	// pointers and counters; clear touches buffers and nothing in the supply
	always_ff @(posedge clk_i) begin
		if (!rstn_i || buf_clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			msg_count <= '0;
		end else begin
			wr_ptr <= wr_ptr + OBUF_AW'(push);
			rd_ptr <= rd_ptr + OBUF_AW'(pop);
			count <= count + (OBUF_AW+1)'(push) - (OBUF_AW+1)'(pop);
			msg_count <= msg_count + (OBUF_AW+1)'(push_term) - (OBUF_AW+1)'(pop_term);
		end
	end

	assign par_tx_data_o = obuf[rd_ptr][7:0];
	assign par_tx_avail_o = buf_avail;
	assign par_eoi_o = 1'b0;

	// millisecond tick for the status snapshot
	logic [31:0] tick_cnt;
	wire tick = (tick_cnt == 32'(STATUS_TICK - 1));
	always_ff @(posedge clk_i) begin
		if (!rstn_i || tick) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	// flags sampled once per tick, so they can lag a read by up to a period
	logic rdy_snap;
	logic mav_snap;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdy_snap <= 1'b0;
			mav_snap <= 1'b0;
		end else if (tick) begin
			rdy_snap <= buf_avail;
			mav_snap <= msg_avail;
		end
	end

	// service request on each rise of message-available, unless talking
	logic mav_prev;
	logic rqs;
	wire mav_rise = msg_avail & ~mav_prev;
	wire srq_set = mav_rise & ~par_talk_i;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mav_prev <= 1'b0;
			rqs <= 1'b0;
		end else begin
			mav_prev <= msg_avail;
			if (srq_set) begin
				rqs <= 1'b1;
			end else if (par_poll_read_i) begin
				rqs <= 1'b0;
			end
		end
	end

	// status byte is always presented for a poll
	always_comb begin
		status_byte_o = 8'h00;
		status_byte_o[SB_RQS_BIT] = rqs;
		status_byte_o[SB_MAV_BIT] = mav_snap;
		status_byte_o[SB_RDY_BIT] = rdy_snap;
	end

	assign par_srq_o = rqs;
	assign par_active_o = par_active;
	assign bus_addr_o = bus_addr;
	assign ext_res_o = ext_res;
	assign crlf_o = crlf;
endmodule

// ### bench/rcfe_props.sv
// concurrent checks on the ports of the remote command front end
`timescale 1ns/100ps
module rcfe_props #(
	parameter int STATUS_TICK = 20
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ser_rx_valid_i,
	input wire logic ser_tx_ready_i,
	input wire logic par_ren_i,
	input wire logic par_talk_i,
	input wire logic par_rx_valid_i,
	input wire logic par_dev_clear_i,
	input wire logic par_poll_read_i,
	input wire logic rsp_valid_i,
	input wire logic test_exit_i,
	input wire logic ser_tx_valid_o,
	input wire rcfe_pkg::rcfe_byte_t ser_tx_data_o,
	input wire logic cmd_valid_o,
	input wire logic par_tx_avail_o,
	input wire logic par_eoi_o,
	input wire logic par_srq_o,
	input wire rcfe_pkg::rcfe_byte_t status_byte_o,
	input wire logic par_active_o,
	input wire rcfe_pkg::rcfe_nib_t bus_addr_o
);
	import rcfe_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// a reply byte offered while the uart stalls
	sequence tx_stalled;
		ser_tx_valid_o && !ser_tx_ready_i;
	endsequence
	// a serial byte arriving alone while the parallel port owns control
	sequence ser_only_byte;
		par_active_o && ser_rx_valid_i && !par_rx_valid_i;
	endsequence

	eoi_low_a: assert property (!par_eoi_o) else $error("end line driven");
	status_spare_a: assert property ((status_byte_o & 8'had) == 8'h00) else $error("spare status bit set");
	active_sticky_a: assert property (par_active_o && !test_exit_i |=> par_active_o)
		else $error("parallel port dropped control");
	active_cause_a: assert property ($rose(par_active_o) |-> $past(par_ren_i, 2) || $past(par_ren_i, 3)
		|| $past(par_ren_i, 4)) else $error("parallel port active without remote enable");
	serial_muted_a: assert property (ser_only_byte |=> !cmd_valid_o) else $error("serial byte obeyed");
	tx_hold_a: assert property (tx_stalled |=> ser_tx_valid_o && $stable(ser_tx_data_o))
		else $error("reply byte lost while stalled");
	clear_empty_a: assert property (par_dev_clear_i && !rsp_valid_i |=> !par_tx_avail_o)
		else $error("buffer kept after clear");
	srq_talk_a: assert property ($rose(par_srq_o) |-> !$past(par_talk_i)) else $error("service request while talker");
	srq_release_a: assert property ($fell(par_srq_o) |-> $past(par_poll_read_i) || $past(par_dev_clear_i)
		|| $past(test_exit_i)) else $error("service request dropped unpolled");
	addr_range_a: assert property (bus_addr_o >= BUS_ADDR_MIN && bus_addr_o <= BUS_ADDR_MAX)
		else $error("bus address out of range");
endmodule

bind rcfe_top rcfe_props #(.STATUS_TICK(STATUS_TICK)) u_props (.clk_i, .rstn_i, .ser_rx_valid_i, .ser_tx_ready_i,
	.par_ren_i, .par_talk_i, .par_rx_valid_i, .par_dev_clear_i, .par_poll_read_i, .rsp_valid_i, .test_exit_i,
	.ser_tx_valid_o, .ser_tx_data_o, .cmd_valid_o, .par_tx_avail_o, .par_eoi_o, .par_srq_o, .status_byte_o,
	.par_active_o, .bus_addr_o);

// ### bench/rcfe_host.sv
// host model: serial terminal with a stalling uart and a parallel-bus controller
`timescale 1ns/100ps
module rcfe_host (
	input wire logic clk_i,
	output logic ser_valid_o,
	output rcfe_pkg::rcfe_byte_t ser_data_o,
	output logic ser_ready_o,
	input wire logic ser_tx_valid_i,
	input wire rcfe_pkg::rcfe_byte_t ser_tx_data_i,
	output logic par_valid_o,
	output rcfe_pkg::rcfe_byte_t par_data_o,
	output logic par_read_o,
	input wire rcfe_pkg::rcfe_byte_t par_tx_data_i
);
	import rcfe_pkg::*;
	string got;
	// counter starts known so the stall pattern is fixed; ready has one driver only
	logic [1:0] cyc = 2'h0;
	initial begin
		{ser_valid_o, par_valid_o, par_read_o} = 3'h0;
		ser_data_o = 8'h00;
		par_data_o = 8'h00;
	end
	// uart takes three bytes in four so the held reply path is used
	always @(posedge clk_i) begin
		if (ser_tx_valid_i && ser_ready_o)
			got = {got, string'(ser_tx_data_i)};
		cyc <= cyc + 2'h1;
		ser_ready_o <= #1 (cyc != 2'h3);
	end
	// whole command lines, CR included; caller waits for the reply first
	task automatic send(input string s, input logic par);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk_i);
			#1;
			if (par) begin
				par_valid_o = 1'b1;
				par_data_o = s[i];
			end else begin
				ser_valid_o = 1'b1;
				ser_data_o = s[i];
			end
		end
		@(posedge clk_i);
		#1;
		ser_valid_o = 1'b0;
		par_valid_o = 1'b0;
		// released lines show no stale byte
		ser_data_o = ~ser_data_o;
		par_data_o = ~par_data_o;
	endtask
	// controller reads the head byte
	task automatic pread();
		@(posedge clk_i);
		#1;
		par_read_o = 1'b1;
		@(posedge clk_i);
		got = {got, string'(par_tx_data_i)};
		#1;
		par_read_o = 1'b0;
	endtask
endmodule

// ### bench/tb_top.sv
// self-checking bench for the remote command front end
`timescale 1ns/100ps
module tb_top;
	import rcfe_pkg::*;
	localparam int TICK = 20;
	logic clk_i, rstn_i, ser_rx_valid_i, ser_tx_valid_o, ser_tx_ready_i, par_ren_i, par_talk_i, par_listen_i;
	logic par_rx_valid_i, par_tx_read_i, par_dev_clear_i, par_poll_read_i, par_tx_avail_o, par_eoi_o, par_srq_o;
	logic par_active_o, test_mode_i, test_exit_i, test_par_addr_we_i, nv_store_o, cmd_valid_o, cmd_end_o;
	logic cmd_reply_en_o, ext_res_o, crlf_o, rsp_valid_i, rsp_last_i, cmd_reject_i, rsp_ready_o, en_seen;
	rcfe_byte_t ser_rx_data_i, ser_tx_data_o, par_rx_data_i, par_tx_data_o, status_byte_o, cmd_data_o, rsp_data_i;
	rcfe_paddr_t test_par_addr_i;
	rcfe_nib_t nv_bus_addr_i, nv_bus_addr_o, bus_addr_o;
	int error_cnt, samples_checked, ends, stores;
	string cmd_s;

	rcfe_top #(.STATUS_TICK(TICK)) u_dut (.*);
	rcfe_host u_host (.clk_i, .ser_valid_o(ser_rx_valid_i), .ser_data_o(ser_rx_data_i), .ser_ready_o(ser_tx_ready_i),
		.ser_tx_valid_i(ser_tx_valid_o), .ser_tx_data_i(ser_tx_data_o), .par_valid_o(par_rx_valid_i),
		.par_data_o(par_rx_data_i), .par_read_o(par_tx_read_i), .par_tx_data_i(par_tx_data_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// handler side: collect command text, ends and store pulses
	always @(posedge clk_i) begin
		if (cmd_valid_o)
			cmd_s = {cmd_s, string'(cmd_data_o)};
		if (cmd_end_o) begin
			ends++;
			en_seen = cmd_reply_en_o;
		end
		if (nv_store_o)
			stores++;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chks(input string n, input string e, input string g);
		samples_checked++;
		if (g != e) begin
			error_cnt++;
			$display("Error %s expected '%s' seen '%s'", n, e, g);
		end
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk_i);
		#1 s = 1'b1;
		@(posedge clk_i);
		#1 s = 1'b0;
	endtask
	// handler echoes the letter, or flags a reject for Z
	task automatic respond(input rcfe_byte_t b);
		@(posedge clk_i);
		#1;
		cmd_reject_i = (b == "Z");
		rsp_valid_i = (b != "Z");
		rsp_data_i = b;
		rsp_last_i = 1'b1;
		do @(posedge clk_i); while (b != "Z" && !rsp_ready_o);
		#1;
		{cmd_reject_i, rsp_valid_i, rsp_last_i} = 3'h0;
		rsp_data_i = ~b;
	endtask
	// one command: text seen by handler, reply enable, reply text ("-" leaves buffer unread)
	task automatic run(input string s, input logic par, input string ecmd, input logic een, input string etx);
		cmd_s = "";
		ends = 0;
		u_host.got = "";
		u_host.send(s, par);
		repeat (4) @(posedge clk_i);
		chks("command", ecmd, cmd_s);
		chk("ends", 8'(ecmd != ""), 8'(ends));
		if (ecmd != "") begin
			chk("reply enable", 8'(een), 8'(en_seen));
			respond(ecmd[0]);
		end
		repeat (40) @(posedge clk_i);
		if (etx != "-") begin
			while (par && par_tx_avail_o)
				u_host.pread();
			chks("reply", etx, u_host.got);
		end
	endtask
	// settings change off the edge, so the design never races the bench
	task automatic restart(input rcfe_paddr_t a);
		@(posedge clk_i);
		#1;
		test_mode_i = 1'b1;
		test_par_addr_i = a;
		pulse(test_par_addr_we_i);
		pulse(test_exit_i);
		test_mode_i = 1'b0;
		repeat (10) @(posedge clk_i);
	endtask
	// bound on a hang, well past the expected run
	initial begin
		repeat (8000) @(posedge clk_i);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		{rstn_i, par_ren_i, par_talk_i, par_listen_i, par_dev_clear_i, par_poll_read_i} = 6'h0;
		{test_mode_i, test_exit_i, test_par_addr_we_i, rsp_valid_i, rsp_last_i, cmd_reject_i} = 6'h0;
		rsp_data_i = 8'h00;
		test_par_addr_i = PAR_ADDR_RESET;
		nv_bus_addr_i = 4'h3;
		repeat (16) @(posedge clk_i);
		#1 rstn_i = 1'b1;
		repeat (3) @(posedge clk_i);
		chk("bus address", 8'h03, 8'(bus_addr_o));
		chk("port state", 8'h00, {par_active_o, crlf_o, ext_res_o, status_byte_o[4:0]});
		run("@3A\r", 0, "A", 1, "A\r");
		run("@5A\r", 0, "", 0, "");
		run("$@3B\r", 0, "B", 0, "");
		run("@3&@X\r", 0, "@X", 1, "@\r");
		u_host.send("@3!5\r", 0);
		repeat (8) @(posedge clk_i);
		chk("locked address", 8'h03, 8'(bus_addr_o));
		run("@3U1\r", 0, "U1", 1, "U\r");
		u_host.send("@3!5\r", 0);
		repeat (8) @(posedge clk_i);
		chk("new address", 8'h05, 8'(bus_addr_o));
		u_host.send("@5!0\r", 0);
		repeat (8) @(posedge clk_i);
		chk("address range", 8'h05, 8'(bus_addr_o));
		chk("early store", 8'h00, 8'(stores));
		run("@5Z\r", 0, "Z", 1, "?\r");
		run("@5Q4\r", 0, "Q4", 0, "");
		chk("extended only", 8'h02, 8'({ext_res_o, crlf_o}));
		run("@5Q6\r", 0, "Q6", 0, "");
		chk("modes", 8'h03, 8'({ext_res_o, crlf_o}));
		run("@5A\r", 0, "A", 1, "A\r\n");
		run("@5~\r", 0, "~", 1, "~\r\n");
		chk("store strobe", 8'h01, 8'(stores));
		restart(PAR_ADDR_OFF);
		chk("stored address", 8'h05, 8'(nv_bus_addr_o));
		chk("exit store", 8'h02, 8'(stores));
		#1;
		par_ren_i = 1'b1;
		par_listen_i = 1'b1;
		repeat (10) @(posedge clk_i);
		chk("disabled port", 8'h00, 8'(par_active_o));
		restart(PAR_ADDR_RESET);
		chk("port active", 8'h01, 8'(par_active_o));
		run("@5A\r", 0, "", 0, "");
		run("Q6\r\n", 1, "Q6", 0, "");
		run("A\r\n", 1, "A", 1, "-");
		repeat (2 * TICK + 4) @(posedge clk_i);
		chk("status", 8'h52, status_byte_o);
		chk("service request", 8'h01, 8'(par_srq_o));
		pulse(par_poll_read_i);
		@(posedge clk_i);
		chk("request released", 8'h00, 8'(par_srq_o));
		repeat (2 * TICK + 4) @(posedge clk_i);
		chk("status polled", 8'h12, status_byte_o);
		run("", 1, "", 0, "A\r\n");
		repeat (2 * TICK + 4) @(posedge clk_i);
		chk("status drained", 8'h00, status_byte_o);
		run("A\r", 1, "A", 1, "-");
		pulse(par_dev_clear_i);
		@(posedge clk_i);
		chk("cleared", 8'h00, 8'(par_tx_avail_o));
		chk("mode kept", 8'h01, 8'(crlf_o));
		// a message that completes while addressed to talk raises no request
		pulse(par_poll_read_i);
		par_talk_i = 1'b1;
		run("A\r", 1, "A", 1, "-");
		chk("talker request", 8'h00, 8'(par_srq_o));
		repeat (2 * TICK + 4) @(posedge clk_i);
		chk("talker status", 8'h12, status_byte_o);
		report_and_stop();
	end
endmodule
